/* core/zero_reset_trigger_control.sv */
// Zero-reset and test-signal trigger control for torque and angle channels
`include "zrt_regs.svh"
`default_nettype none
module zero_reset_trigger_control #(
	parameter int unsigned POWER_CYC =
		`ZRT_POWER_LED_MS * (`ZRT_CLK_HZ / 1000),
	parameter int unsigned ZERO_CYC =
		`ZRT_ZERO_TIME_MS * (`ZRT_CLK_HZ / 1000),
	parameter int unsigned BLINK_HALF_CYC =
		`ZRT_BLINK_HALF_MS * (`ZRT_CLK_HZ / 1000),
	parameter int unsigned BLINKS = `ZRT_BLINK_COUNT,
	parameter logic [zrt_pkg::VAL_W-1:0] CAL_JUMP = `ZRT_CAL_JUMP_DEF
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Remote push buttons, active high, asynchronous
	input wire logic i_btn_torque,
	input wire logic i_btn_angle,
	// Terminal character strobe
	input wire logic i_term_valid,
	input wire logic [7:0] i_term_char,
	// CAN command strobe
	input wire logic i_can_valid,
	input wire logic [15:0] i_can_cmd,
	// Measured samples
	input wire logic i_sample_valid,
	input wire zrt_pkg::chan_pair_s i_sample,
	// Corrected outputs
	output zrt_pkg::chan_pair_s o_value,
	output logic o_value_valid,
	// Status and LEDs
	output logic o_cal_jump,
	output zrt_pkg::chan_sel_s o_busy,
	output logic o_led_torque,
	output logic o_led_angle
);

	// ------------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------------------
	// Button synchronisers and press detection
	// ------------------------------------------------------------------------
	logic [1:0] btn_s1_r;
	logic [1:0] btn_s2_r;
	logic [1:0] btn_d_r;
	logic [1:0] btn_press;

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			btn_s1_r <= 2'b00;
			btn_s2_r <= 2'b00;
			btn_d_r <= 2'b00;
		end
		else
		begin
			btn_s1_r <= {i_btn_torque, i_btn_angle};
			btn_s2_r <= btn_s1_r;
			btn_d_r <= btn_s2_r;
		end
	end

	assign btn_press = btn_s2_r & ~btn_d_r;

	// ------------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------------
	zrt_pkg::chan_sel_s req_term;
	zrt_pkg::chan_sel_s req_can;
	zrt_pkg::chan_sel_s req_btn;
	zrt_pkg::chan_sel_s req_all;
	logic term_zero;
	logic term_jump;

	assign term_zero = i_term_valid && i_term_char == `ZRT_TERM_ZERO_BOTH;
	assign term_jump = i_term_valid && i_term_char == `ZRT_TERM_TEST_JUMP;
	assign req_term = '{torque: term_zero, angle: term_zero};

	assign req_can.torque = i_can_valid
		&& i_can_cmd == `ZRT_CAN_ZERO_TORQUE;
	assign req_can.angle = i_can_valid
		&& i_can_cmd == `ZRT_CAN_ZERO_ANGLE;

	assign req_btn = '{torque: btn_press[1], angle: btn_press[0]};

	assign req_all = req_term | req_can | req_btn;

	// ------------------------------------------------------------------------
	// Zero sequencer
	// ------------------------------------------------------------------------
	zrt_pkg::zero_state_e state_r;
	zrt_pkg::chan_sel_s sel_r;
	logic [31:0] cnt_r;
	logic accept;
	logic zero_done;
	logic power_done;

	// Requests, the other button's among them, only taken when idle
	assign accept = state_r == zrt_pkg::ST_IDLE && req_all != 2'b00;
	// Adjustment ends at the seven second mark
	assign zero_done = state_r == zrt_pkg::ST_ZERO && cnt_r == ZERO_CYC - 1;
	assign power_done = state_r == zrt_pkg::ST_POWER
		&& cnt_r == POWER_CYC - 1;

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= zrt_pkg::ST_POWER;
		else
		begin
			unique case (state_r)
				zrt_pkg::ST_POWER:
					if (power_done)
						state_r <= zrt_pkg::ST_IDLE;
				zrt_pkg::ST_IDLE:
					if (accept)
						state_r <= zrt_pkg::ST_ZERO;
				zrt_pkg::ST_ZERO:
					if (zero_done)
						state_r <= zrt_pkg::ST_IDLE;
				default:
					state_r <= zrt_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 32'h0000_0000;
		else if (accept || power_done || zero_done)
			cnt_r <= 32'h0000_0000;
		else if (state_r != zrt_pkg::ST_IDLE)
			cnt_r <= cnt_r + 32'h0000_0001;
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sel_r <= 2'b00;
		else if (accept)
			sel_r <= req_all;
		else if (zero_done)
			sel_r <= 2'b00;
	end

	// Busy shown from a flop; clears on the completion edge
	assign o_busy = sel_r;

	// ------------------------------------------------------------------------
	// Offsets and corrected outputs
	// ------------------------------------------------------------------------
	zrt_pkg::chan_pair_s offset_r;
	zrt_pkg::chan_pair_s last_r;
	zrt_pkg::chan_pair_s value_r;
	logic value_valid_r;
	logic cal_jump_r;

	// Latest sample held so the capture sees the present value
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			last_r <= {`ZRT_OFFSET_RST, `ZRT_OFFSET_RST};
		else if (i_sample_valid)
			last_r <= i_sample;
	end

	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			offset_r <= {`ZRT_OFFSET_RST, `ZRT_OFFSET_RST};
		else if (zero_done)
		begin
			if (sel_r.torque)
				offset_r.torque <= last_r.torque;
			if (sel_r.angle)
				offset_r.angle <= last_r.angle;
		end
	end

	// Test signal toggles on each request
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cal_jump_r <= 1'b0;
		else if (term_jump)
			cal_jump_r <= !cal_jump_r;
	end

	// Subtract offset; add jump to torque
	always_ff @(posedge i_clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			value_r <= {`ZRT_OFFSET_RST, `ZRT_OFFSET_RST};
			value_valid_r <= 1'b0;
		end
		else
		begin
			value_valid_r <= i_sample_valid;
			if (i_sample_valid)
			begin
				value_r.torque <= i_sample.torque - offset_r.torque
					+ (cal_jump_r ? CAL_JUMP : `ZRT_OFFSET_RST);
				value_r.angle <= i_sample.angle - offset_r.angle;
			end
		end
	end

	assign o_value = value_r;
	assign o_value_valid = value_valid_r;
	assign o_cal_jump = cal_jump_r;

	// ------------------------------------------------------------------------
	// Button LEDs
	// ------------------------------------------------------------------------
	logic power_led;
	logic blink_torque;
	logic blink_angle;

	assign power_led = state_r == zrt_pkg::ST_POWER;
	// Blink only for an accepted button press
	assign blink_torque = accept && req_btn.torque;
	assign blink_angle = accept && req_btn.angle;

	led_blinker #(
		.HALF_CYC(BLINK_HALF_CYC),
		.BLINKS(BLINKS)
	) u_led_torque (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_force(power_led),
		.i_start(blink_torque),
		.o_led(o_led_torque)
	);

	led_blinker #(
		.HALF_CYC(BLINK_HALF_CYC),
		.BLINKS(BLINKS)
	) u_led_angle (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_n),
		.i_force(power_led),
		.i_start(blink_angle),
		.o_led(o_led_angle)
	);

endmodule
`default_nettype wire

/* core/zrt_regs.svh */
// Constants of the zero-reset and test-signal trigger control
`ifndef ZRT_REGS_SVH
`define ZRT_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------------------
`define ZRT_CLK_HZ 50000000
`define ZRT_POWER_LED_MS 1000
`define ZRT_ZERO_TIME_MS 7000
`define ZRT_BLINK_HALF_MS 200
`define ZRT_BLINK_COUNT 3

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define ZRT_TERM_ZERO_BOTH 8'h61
`define ZRT_TERM_TEST_JUMP 8'h62
`define ZRT_CAN_ZERO_TORQUE 16'h04B1
`define ZRT_CAN_ZERO_ANGLE 16'h04B4

// ----------------------------------------------------------------------------
// Reset value and default test jump
// ----------------------------------------------------------------------------
`define ZRT_OFFSET_RST 24'h00_0000
`define ZRT_CAL_JUMP_DEF 24'h00_270B

`endif

/* core/zrt_pkg.sv */
// Types of the zero-reset and test-signal trigger control
`default_nettype none
package zrt_pkg;

	localparam int unsigned VAL_W = 24;

	typedef logic signed [VAL_W-1:0] val_t;

	// One value for each measuring channel
	typedef struct packed {
		val_t torque;
		val_t angle;
	} chan_pair_s;

	// Channel select, one bit per channel
	typedef struct packed {
		logic torque;
		logic angle;
	} chan_sel_s;

	typedef enum logic [2:0] {
		ST_POWER = 3'b001,
		ST_IDLE = 3'b010,
		ST_ZERO = 3'b100
	} zero_state_e;

endpackage
`default_nettype wire

/* core/led_blinker.sv */
// Button LED driver: forced on, or a burst of blinks after a start pulse
`default_nettype none
module led_blinker #(
	parameter int unsigned HALF_CYC = 10000000,
	parameter int unsigned BLINKS = 3
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Control
	input wire logic i_force,
	input wire logic i_start,
	// LED
	output logic o_led
);

	localparam int unsigned PHASES = 2 * BLINKS;

	logic [31:0] cnt_r;
	logic [7:0] phase_r;
	logic led_r;

	// ------------------------------------------------------------------------
	// Blink sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_r <= 32'h0000_0000;
			phase_r <= 8'h00;
		end
		else if (i_start)
		begin
			cnt_r <= 32'h0000_0000;
			phase_r <= 8'(PHASES);
		end
		else if (phase_r != 8'h00)
		begin
			if (cnt_r == HALF_CYC - 1)
			begin
				cnt_r <= 32'h0000_0000;
				phase_r <= phase_r - 8'h01;
			end
			else
				cnt_r <= cnt_r + 32'h0000_0001;
		end
	end

	// Next half lit when an even, nonzero count remains; burst opens lit
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			led_r <= 1'b0;
		else if (i_force)
			led_r <= 1'b1;
		else if (i_start)
			led_r <= 1'b1;
		else if (phase_r != 8'h00 && cnt_r == HALF_CYC - 1)
			led_r <= (phase_r != 8'h01) && phase_r[0];
		else if (phase_r == 8'h00)
			led_r <= 1'b0;
	end

	assign o_led = led_r;

endmodule
`default_nettype wire

/* dv/zrt_checker.sv */
// Port assertions for the zero-reset and test-signal trigger control
`default_nettype none
module zrt_checker #(
	parameter int unsigned ZERO_CYC = 50
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	// Requests
	input wire logic i_term_valid,
	input wire logic [7:0] i_term_char,
	input wire logic i_can_valid,
	input wire logic [15:0] i_can_cmd,
	input wire logic i_sample_valid,
	// Outputs
	input wire logic o_value_valid,
	input wire logic o_cal_jump,
	input wire zrt_pkg::chan_sel_s o_busy,
	input wire logic o_led_torque,
	input wire logic o_led_angle
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	// Idle excludes the power phase, where the LEDs are on
	wire logic idle = o_busy == 2'h0 && !o_led_torque && !o_led_angle;
	int unsigned bcnt;
	always_ff @(posedge i_clk_sys or negedge i_nrst)
		if (!i_nrst)
			bcnt <= 0;
		else
			bcnt <= (o_busy != 2'h0) ? bcnt + 1 : 0;
	chk_can_torque: assert property (
		i_can_valid && i_can_cmd == 16'h04B1 && idle |=> o_busy == 2'h2)
		else $error("torque zero not started");
	chk_can_angle: assert property (
		i_can_valid && i_can_cmd == 16'h04B4 && idle |=> o_busy == 2'h1)
		else $error("angle zero not started");
	chk_term_both: assert property (
		i_term_valid && i_term_char == 8'h61 && idle |=> o_busy == 2'h3)
		else $error("both zero not started");
	chk_jump_toggle: assert property (
		i_term_valid && i_term_char == 8'h62 |=> o_cal_jump != $past(o_cal_jump))
		else $error("test jump not toggled");
	chk_busy_len: assert property (
		$fell(o_busy != 2'h0) |-> bcnt + 3 >= ZERO_CYC && bcnt <= ZERO_CYC + 1)
		else $error("zero period length wrong");
	chk_busy_held: assert property (
		o_busy != 2'h0 && $past(o_busy) != 2'h0 |-> o_busy == $past(o_busy))
		else $error("busy channel changed mid zero");
	chk_power_leds: assert property (
		$rose(i_nrst) |-> ##[1:4] o_led_torque && o_led_angle)
		else $error("power LEDs not lit");
	chk_value_strobe: assert property (
		o_value_valid == $past(i_sample_valid))
		else $error("value strobe not one cycle after sample");
	cover property (o_busy == 2'h3);
	cover property ($rose(o_cal_jump));
	cover property ($fell(o_led_torque) && o_busy != 2'h0);
endmodule
bind zero_reset_trigger_control zrt_checker #(.ZERO_CYC(ZERO_CYC)) i_chk (
	.i_clk_sys, .i_nrst, .i_term_valid, .i_term_char, .i_can_valid,
	.i_can_cmd, .i_sample_valid, .o_value_valid, .o_cal_jump, .o_busy,
	.o_led_torque, .o_led_angle);
`default_nettype wire

/* dv/zrt_far_side.sv */
// Far-side model: remote buttons, serial terminal and CAN host
`default_nettype none
module zrt_far_side (
	// Clock
	input wire logic i_clk_sys,
	// Outputs to the block
	output logic o_btn_torque,
	output logic o_btn_angle,
	output logic o_term_valid,
	output logic [7:0] o_term_char,
	output logic o_can_valid,
	output logic [15:0] o_can_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{o_btn_torque, o_btn_angle, o_term_valid, o_can_valid} = 4'h0;
		o_term_char = 8'h00;
		o_can_cmd = 16'h0000;
	end
	// Held past the two-flop sync, no bounce
	task automatic press(input logic t, input logic a);
		@(posedge i_clk_sys);
		o_btn_torque <= t;
		o_btn_angle <= a;
		repeat (6) @(posedge i_clk_sys);
		o_btn_torque <= 1'h0;
		o_btn_angle <= 1'h0;
	endtask
	// Code lines idle inverted so a stale code never looks valid
	task automatic term(input logic [7:0] c);
		@(posedge i_clk_sys);
		o_term_valid <= 1'h1;
		o_term_char <= c;
		@(posedge i_clk_sys);
		o_term_valid <= 1'h0;
		o_term_char <= ~c;
	endtask
	task automatic can(input logic [15:0] c);
		@(posedge i_clk_sys);
		o_can_valid <= 1'h1;
		o_can_cmd <= c;
		@(posedge i_clk_sys);
		o_can_valid <= 1'h0;
		o_can_cmd <= ~c;
	endtask
endmodule
`default_nettype wire

/* dv/zero_reset_trigger_control_tb_top.sv */
// Testbench top for the zero-reset and test-signal trigger control
`default_nettype none
module zero_reset_trigger_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, sv, vv, jump, lt, la, bt, ba, tv, cv;
	logic [7:0] tc;
	logic [15:0] cc;
	zrt_pkg::chan_pair_s smp, val;
	zrt_pkg::chan_sel_s busy;
	int miscompares, checks_done, rt, ra, on_cnt, lt_on;
	zero_reset_trigger_control #(.POWER_CYC(20), .ZERO_CYC(50),
		.BLINK_HALF_CYC(4), .BLINKS(3)) i_dut (.i_clk_sys(clk),
		.i_nrst(nrst), .i_btn_torque(bt), .i_btn_angle(ba),
		.i_term_valid(tv), .i_term_char(tc), .i_can_valid(cv),
		.i_can_cmd(cc), .i_sample_valid(sv), .i_sample(smp),
		.o_value(val), .o_value_valid(vv), .o_cal_jump(jump),
		.o_busy(busy), .o_led_torque(lt), .o_led_angle(la));
	zrt_far_side i_far (.i_clk_sys(clk), .o_btn_torque(bt),
		.o_btn_angle(ba), .o_term_valid(tv), .o_term_char(tc),
		.o_can_valid(cv), .o_can_cmd(cc));
	initial
	begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	always @(posedge lt) rt++;
	always @(posedge la) ra++;
	always @(posedge clk) if (lt && la) on_cnt++;
	always @(posedge clk) if (lt) lt_on++;
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [48:0] got, exp);
		checks_done++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_busy(input logic want);
		for (int n = 0; (|busy) !== want; n++)
		begin
			if (n == 100)
			begin
				miscompares++;
				end_of_test();
			end
			@(posedge clk);
			#1;
		end
	endtask
	task automatic samp(input zrt_pkg::val_t t, a, et, ea);
		@(posedge clk);
		sv <= 1'h1;
		smp <= {t, a};
		@(posedge clk);
		sv <= 1'h0;
		smp <= ~{t, a};
		#1;
		chk({vv, val}, {1'h1, et, ea});
	endtask
	task automatic zero(input zrt_pkg::chan_sel_s exp);
		wait_busy(1'h1);
		chk(49'(busy), 49'(exp));
		wait_busy(1'h0);
	endtask
	task automatic t_power;
		repeat (4) @(posedge clk);
		i_far.can(16'h04B1);
		@(posedge clk);
		#1;
		chk(49'({lt, la, busy}), 49'(4'hC));
		for (int n = 0; lt && n < 40; n++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(49'(on_cnt), 49'(20));
	endtask
	task automatic t_can;
		samp(24'h00_0064, 24'h00_0007, 24'h00_0064, 24'h00_0007);
		i_far.can(16'h04B1);
		zero(2'h2);
		samp(24'h00_0082, 24'h00_0009, 24'h00_001E, 24'h00_0009);
		samp(24'h00_0005, 24'h00_0014, 24'hFF_FFA1, 24'h00_0014);
		i_far.can(16'h04B4);
		zero(2'h1);
		samp(24'h00_0000, 24'h00_0019, 24'hFF_FF9C, 24'h00_0005);
	endtask
	task automatic t_term;
		i_far.term(8'h61);
		zero(2'h3);
		samp(24'h00_000A, 24'h00_001E, 24'h00_000A, 24'h00_0005);
		i_far.term(8'h62);
		samp(24'h00_000A, 24'h00_001E, 24'h00_2715, 24'h00_0005);
		i_far.term(8'h62);
		samp(24'h00_000A, 24'h00_001E, 24'h00_000A, 24'h00_0005);
	endtask
	task automatic t_btn;
		rt = 0;
		ra = 0;
		lt_on = 0;
		i_far.press(1'h1, 1'h0);
		chk(49'(busy), 49'(2'h2));
		i_far.press(1'h0, 1'h1);
		chk(49'(busy), 49'(2'h2));
		wait_busy(1'h0);
		chk(49'({rt, ra}), 49'({32'd3, 32'd0}));
		// Three lit halves of four cycles each
		chk(49'(lt_on), 49'(12));
		i_far.press(1'h0, 1'h1);
		chk(49'(busy), 49'(2'h1));
		wait_busy(1'h0);
		chk(49'(ra), 49'(3));
	endtask
	// Unknown codes start nothing; both buttons together zero both
	task automatic t_other;
		i_far.can(16'h04B2);
		i_far.term(8'h63);
		repeat (2) @(posedge clk);
		#1;
		chk(49'({jump, busy}), 49'(3'h0));
		i_far.press(1'h1, 1'h1);
		chk(49'(busy), 49'(2'h3));
		wait_busy(1'h0);
		samp(24'h00_0014, 24'h00_001E, 24'h00_000A, 24'h00_0000);
	endtask
	initial
	begin
		nrst = 1'h0;
		sv = 1'h0;
		smp = '0;
		{miscompares, checks_done, rt, ra, on_cnt, lt_on} = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'h1;
		t_power();
		t_can();
		t_term();
		t_btn();
		t_other();
		end_of_test();
	end
endmodule
`default_nettype wire
